// ===== hw/analog_input_conditioning.sv
// Analog command conditioning: offset, deadband, filter, scaling, threshold.
//
// Local design decisions: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none
module analog_input_conditioning #(
	parameter int SAMPLE_RATE_HZ = 10000
) (
	// Clock and reset.
	input  wire logic                                          clk_sys,
	input  wire logic                                          reset_n,
	// Avalon-MM slave.
	input  wire logic [analog_input_conditioning_pkg::ADDR_W-1:0] address,
	input  wire logic                                          read,
	input  wire logic                                          write,
	input  wire logic [3:0]                                    byteenable,
	input  wire logic [analog_input_conditioning_pkg::DATA_W-1:0] writedata,
	output logic      [analog_input_conditioning_pkg::DATA_W-1:0] readdata,
	output logic                                               waitrequest,
	// Converter samples, signed millivolts, same clock domain.
	input  wire logic                                          sample_valid,
	input  wire logic signed [15:0]                            sample_mv,
	// Conditioned commands.
	output analog_input_conditioning_pkg::control_mode_t       active_mode,
	output logic                                               command_valid,
	output logic signed [31:0]                                 position_cmd,
	output logic signed [31:0]                                 velocity_cmd,
	output logic        [15:0]                                 torque_limit,
	output logic        [31:0]                                 velocity_limit,
	output logic                                               sensor_state
);
	import analog_input_conditioning_pkg::*;

	// Filter coefficient per 0.1 Hz step, in COEF_FRAC fraction bits.
	localparam longint FILTER_K = TWO_PI_Q24 / (10 * SAMPLE_RATE_HZ);
	localparam logic [31:0] COEF_ONE = 32'h01000000;

	// Software-visible settings.
	control_mode_t      mode;
	logic signed [31:0] position_gain;
	logic        [6:0]  velocity_gain;
	logic        [11:0] torque_gain;
	logic signed [15:0] input_offset;
	logic        [7:0]  input_deadband;
	logic        [14:0] input_filter_cutoff;
	logic signed [15:0] input_threshold;
	logic               torque_velocity_limit_source;
	logic        [16:0] software_speed_limit;
	logic               read_ack;
	control_mode_t      next_mode;
	logic signed [31:0] next_position_gain;
	logic        [6:0]  next_velocity_gain;
	logic        [11:0] next_torque_gain;
	logic signed [15:0] next_input_offset;
	logic        [7:0]  next_input_deadband;
	logic        [14:0] next_input_filter_cutoff;
	logic signed [15:0] next_input_threshold;
	logic               next_torque_velocity_limit_source;
	logic        [16:0] next_software_speed_limit;
	logic               next_read_ack;
	logic        [31:0] next_readdata;

	// Sample pipeline state.
	logic               s1_valid, s2_valid, s3_valid;
	logic signed [15:0] s1_mv, s2_mv;
	logic signed [32:0] filter_acc;
	logic               next_s1_valid, next_s2_valid, next_s3_valid;
	logic signed [15:0] next_s1_mv, next_s2_mv;
	logic signed [32:0] next_filter_acc;
	logic               next_command_valid;
	logic signed [31:0] next_position_cmd, next_velocity_cmd;
	logic        [15:0] next_torque_limit;
	logic        [31:0] next_velocity_limit;
	logic               next_sensor_state;
	logic signed [15:0] filtered_mv;

	// Saturate a signed word into a range; writes outside a range are
	// pulled to the nearest bound instead of being refused.
	function automatic logic [31:0] clamp(input logic [31:0] v,
			input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] r;
		r = v;
		if ($signed(v) < $signed(lo))
			r = lo;
		if ($signed(v) > $signed(hi))
			r = hi;
		return r;
	endfunction

	// Merge the enabled byte lanes of a write into the old word.
	function automatic logic [31:0] merge(input logic [31:0] old_word,
			input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old_word;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		end
		return r;
	endfunction

	// Reads wait one cycle so read data comes from a flip-flop.
	assign waitrequest = read && !read_ack;
	assign filtered_mv = 16'(filter_acc >>> ACC_FRAC);

	// Register file next state: decode, lane merge and range clamp.
	always_comb begin
		logic [31:0] wv;
		wv = 32'h0;
		next_mode = mode;
		next_position_gain = position_gain;
		next_velocity_gain = velocity_gain;
		next_torque_gain = torque_gain;
		next_input_offset = input_offset;
		next_input_deadband = input_deadband;
		next_input_filter_cutoff = input_filter_cutoff;
		next_input_threshold = input_threshold;
		next_torque_velocity_limit_source = torque_velocity_limit_source;
		next_software_speed_limit = software_speed_limit;
		next_read_ack = read && !read_ack;
		next_readdata = readdata;
		if (write) begin
			case (address)
			REG_MODE: begin
				wv = merge({30'h0, mode}, writedata, byteenable);
				if (wv[1:0] != 2'b11)
					next_mode = control_mode_t'(wv[1:0]);
			end
			REG_POSITION_GAIN: begin
				wv = merge(position_gain, writedata, byteenable);
				next_position_gain = clamp(wv, POSITION_GAIN_MIN,
					POSITION_GAIN_MAX);
			end
			REG_VELOCITY_GAIN: begin
				wv = merge({25'h0, velocity_gain}, writedata, byteenable);
				next_velocity_gain = 7'(clamp(wv, 32'h0, VELOCITY_GAIN_MAX));
			end
			REG_TORQUE_GAIN: begin
				wv = merge({20'h0, torque_gain}, writedata, byteenable);
				next_torque_gain = 12'(clamp(wv, 32'h0, TORQUE_GAIN_MAX));
			end
			REG_OFFSET: begin
				wv = merge(32'(input_offset), writedata, byteenable);
				next_input_offset = 16'(clamp(wv, MV_MIN, MV_MAX));
			end
			REG_DEADBAND: begin
				wv = merge({24'h0, input_deadband}, writedata, byteenable);
				next_input_deadband = 8'(clamp(wv, 32'h0, DEADBAND_MAX));
			end
			REG_FILTER: begin
				wv = merge({17'h0, input_filter_cutoff}, writedata,
					byteenable);
				next_input_filter_cutoff = 15'(clamp(wv, 32'h0, FILTER_MAX));
			end
			REG_THRESHOLD: begin
				wv = merge(32'(input_threshold), writedata, byteenable);
				next_input_threshold = 16'(clamp(wv, MV_MIN, MV_MAX));
			end
			REG_LIMIT_SOURCE: begin
				wv = merge({31'h0, torque_velocity_limit_source}, writedata,
					byteenable);
				next_torque_velocity_limit_source = wv[0];
			end
			REG_SW_SPEED_LIM: begin
				wv = merge({15'h0, software_speed_limit}, writedata,
					byteenable);
				next_software_speed_limit = 17'(clamp(wv, 32'h0,
					SW_SPEED_LIM_MAX));
			end
			default: begin
				wv = 32'h0;
			end
			endcase
		end
		if (read && !read_ack) begin
			case (address)
			REG_MODE:          next_readdata = {30'h0, mode};
			REG_POSITION_GAIN: next_readdata = position_gain;
			REG_VELOCITY_GAIN: next_readdata = {25'h0, velocity_gain};
			REG_TORQUE_GAIN:   next_readdata = {20'h0, torque_gain};
			REG_OFFSET:        next_readdata = 32'(input_offset);
			REG_DEADBAND:      next_readdata = {24'h0, input_deadband};
			REG_FILTER:        next_readdata = {17'h0, input_filter_cutoff};
			REG_THRESHOLD:     next_readdata = 32'(input_threshold);
			REG_LIMIT_SOURCE:
				next_readdata = {31'h0, torque_velocity_limit_source};
			REG_SW_SPEED_LIM:  next_readdata = {15'h0, software_speed_limit};
			REG_FILTERED:      next_readdata = 32'(filtered_mv);
			REG_STATUS:        next_readdata = {31'h0, sensor_state};
			default:           next_readdata = 32'h0;
			endcase
		end
	end

	// Register file storage.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			mode <= MODE_POSITION;
			position_gain <= POSITION_GAIN_RST;
			velocity_gain <= VELOCITY_GAIN_RST[6:0];
			torque_gain <= TORQUE_GAIN_RST[11:0];
			input_offset <= OFFSET_RST[15:0];
			input_deadband <= DEADBAND_RST[7:0];
			input_filter_cutoff <= FILTER_RST[14:0];
			input_threshold <= THRESHOLD_RST[15:0];
			torque_velocity_limit_source <= LIMIT_SOURCE_RST;
			software_speed_limit <= SW_SPEED_LIM_RST[16:0];
			read_ack <= 1'b0;
			readdata <= 32'h0;
		end else begin
			mode <= next_mode;
			position_gain <= next_position_gain;
			velocity_gain <= next_velocity_gain;
			torque_gain <= next_torque_gain;
			input_offset <= next_input_offset;
			input_deadband <= next_input_deadband;
			input_filter_cutoff <= next_input_filter_cutoff;
			input_threshold <= next_input_threshold;
			torque_velocity_limit_source <= next_torque_velocity_limit_source;
			software_speed_limit <= next_software_speed_limit;
			read_ack <= next_read_ack;
			readdata <= next_readdata;
		end
	end

	// Sample pipeline: one stage per step so timing stays short.
	always_comb begin
		logic signed [16:0] corr;
		logic        [15:0] mag;
		logic signed [33:0] diff;
		logic        [31:0] coef;
		logic signed [63:0] prod;
		logic signed [47:0] pos_full;
		logic signed [31:0] vel_full;
		logic        [31:0] abs_f;
		logic        [31:0] torque_full;
		logic        [31:0] vlim_full;
		corr = 17'(sample_mv) - 17'(input_offset);
		mag = s1_mv[15] ? 16'(-s1_mv) : 16'(s1_mv);
		diff = 34'(s2_mv) * 34'sh10000 - 34'(filter_acc);
		coef = 32'(longint'(input_filter_cutoff) * FILTER_K);
		prod = 64'sh0;
		abs_f = filtered_mv[15] ? 32'(-32'(filtered_mv)) : 32'(filtered_mv);
		pos_full = 48'(filtered_mv) * 48'(position_gain)
			/ 48'(FULL_SCALE_MV);
		// The gain is cast signed so a negative input keeps its sign.
		vel_full = 32'(filtered_mv) * $signed(32'(velocity_gain))
			/ 32'(VEL_DIVISOR);
		torque_full = abs_f * 32'(torque_gain) / 32'(FULL_SCALE_MV);
		vlim_full = abs_f * 32'(velocity_gain) / 32'(VEL_DIVISOR);
		next_s1_valid = sample_valid;
		next_s1_mv = s1_mv;
		next_s2_valid = s1_valid;
		next_s2_mv = s2_mv;
		next_s3_valid = s2_valid;
		next_filter_acc = filter_acc;
		next_command_valid = s3_valid;
		next_position_cmd = position_cmd;
		next_velocity_cmd = velocity_cmd;
		next_torque_limit = torque_limit;
		next_velocity_limit = velocity_limit;
		next_sensor_state = sensor_state;
		// Offset correction, held to the 10 V span.
		if (sample_valid) begin
			next_s1_mv = 16'(clamp(32'(corr), MV_MIN, MV_MAX)); // [RL4][RL10]
		end
		// Symmetric deadband, boundary included in the zero zone.
		if (s1_valid) begin
			next_s2_mv = (mag <= 16'(input_deadband)) ? 16'sh0 : s1_mv; // [RL5]
		end
		// First-order low-pass; a cutoff of zero bypasses the filter, and
		// a cutoff above the sample rate's reach saturates to pass-through.
		if (s2_valid) begin
			if (input_filter_cutoff == 15'h0 || coef >= COEF_ONE) begin
				next_filter_acc = 33'(s2_mv) * 33'sh10000; // [RL6]
			end else begin
				prod = 64'(diff) * $signed({32'h0, coef});
				next_filter_acc = filter_acc + 33'(prod >>> COEF_FRAC); // [RL6]
			end
		end
		// Gain scaling for the active mode; other mode outputs read zero.
		if (s3_valid) begin
			next_position_cmd = 32'sh0;
			next_velocity_cmd = 32'sh0;
			next_torque_limit = 16'h0;
			next_velocity_limit = 32'h0;
			next_sensor_state = (filtered_mv >= input_threshold); // [RL7]
			case (mode)
			MODE_POSITION: next_position_cmd = 32'(pos_full); // [RL1][RL10]
			MODE_VELOCITY: next_velocity_cmd = vel_full; // [RL2]
			MODE_TORQUE: begin
				next_torque_limit = 16'(torque_full); // [RL3]
				// A limit is always driven so the motor never runs away.
				next_velocity_limit = torque_velocity_limit_source ?
					vlim_full : 32'(software_speed_limit); // [RL8][RL9]
			end
			default: next_position_cmd = 32'sh0;
			endcase
		end
	end

	// Sample pipeline storage.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s1_valid <= 1'b0;
			s2_valid <= 1'b0;
			s3_valid <= 1'b0;
			s1_mv <= 16'sh0;
			s2_mv <= 16'sh0;
			filter_acc <= 33'sh0;
			command_valid <= 1'b0;
			position_cmd <= 32'sh0;
			velocity_cmd <= 32'sh0;
			torque_limit <= 16'h0;
			velocity_limit <= 32'h0;
			sensor_state <= 1'b0;
		end else begin
			s1_valid <= next_s1_valid;
			s2_valid <= next_s2_valid;
			s3_valid <= next_s3_valid;
			s1_mv <= next_s1_mv;
			s2_mv <= next_s2_mv;
			filter_acc <= next_filter_acc;
			command_valid <= next_command_valid;
			position_cmd <= next_position_cmd;
			velocity_cmd <= next_velocity_cmd;
			torque_limit <= next_torque_limit;
			velocity_limit <= next_velocity_limit;
			sensor_state <= next_sensor_state;
		end
	end

	assign active_mode = mode;
endmodule // analog_input_conditioning
`default_nettype wire

// ===== inc/analog_input_conditioning_pkg.sv
// Constants, register map and types of the analog input conditioning block.
//
// Notes on behaviour
// RL1: Position mode: 10 V commands position gain pulses.
// RL2: Velocity mode: 10 V commands velocity gain rps.
// RL3: Torque mode: 10 V magnitude gives torque limit.
// RL4: Subtract signed millivolt offset from each sample.
// RL5: Inputs inside symmetric deadband become exactly zero.
// RL6: Low-pass filter with cutoff in 0.1 Hz steps.
// RL7: Compare input against signed threshold for sensor state.
// RL8: Torque mode always drives a velocity limit.
// RL9: Limit source: 0 software setting, 1 analog.
// RL10: Order: offset, deadband, filter, then gain scaling.
`default_nettype none
package analog_input_conditioning_pkg;
	// Avalon-MM byte address width and data width.
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;

	// Register byte offsets.
	localparam logic [5:0] REG_MODE          = 6'h00;
	localparam logic [5:0] REG_POSITION_GAIN = 6'h04;
	localparam logic [5:0] REG_VELOCITY_GAIN = 6'h08;
	localparam logic [5:0] REG_TORQUE_GAIN   = 6'h0c;
	localparam logic [5:0] REG_OFFSET        = 6'h10;
	localparam logic [5:0] REG_DEADBAND      = 6'h14;
	localparam logic [5:0] REG_FILTER        = 6'h18;
	localparam logic [5:0] REG_THRESHOLD     = 6'h1c;
	localparam logic [5:0] REG_LIMIT_SOURCE  = 6'h20;
	localparam logic [5:0] REG_SW_SPEED_LIM  = 6'h24;
	localparam logic [5:0] REG_FILTERED      = 6'h28;
	localparam logic [5:0] REG_STATUS        = 6'h2c;

	// Reset values and legal ranges (decimal in comments).
	localparam logic [31:0] POSITION_GAIN_RST = 32'h00001f40; // 8000
	localparam logic [31:0] POSITION_GAIN_MAX = 32'h7fffffff;
	localparam logic [31:0] POSITION_GAIN_MIN = 32'h80000001;
	localparam logic [31:0] VELOCITY_GAIN_RST = 32'h00000032; // 50
	localparam logic [31:0] VELOCITY_GAIN_MAX = 32'h00000064; // 100
	localparam logic [31:0] TORQUE_GAIN_RST   = 32'h000003e8; // 1000
	localparam logic [31:0] TORQUE_GAIN_MAX   = 32'h00000bb8; // 3000
	localparam logic [31:0] OFFSET_RST        = 32'h00000000;
	localparam logic [31:0] MV_MAX            = 32'h00002710; // 10000
	localparam logic [31:0] MV_MIN            = 32'hffffd8f0; // -10000
	localparam logic [31:0] DEADBAND_RST      = 32'h00000000;
	localparam logic [31:0] DEADBAND_MAX      = 32'h000000ff; // 255
	localparam logic [31:0] FILTER_RST        = 32'h000003e8; // 1000
	localparam logic [31:0] FILTER_MAX        = 32'h00004e20; // 20000
	localparam logic [31:0] THRESHOLD_RST     = 32'h00001388; // 5000
	localparam logic        LIMIT_SOURCE_RST  = 1'h1;
	localparam logic [31:0] SW_SPEED_LIM_RST  = 32'h0000c350; // 50000
	localparam logic [31:0] SW_SPEED_LIM_MAX  = 32'h000186a0; // 100000

	// Full scale of 10 V expressed in millivolts.
	localparam int FULL_SCALE_MV = 10000;
	// Velocity outputs are in milli-rps: gain * mV * 1000 / 10000.
	localparam int VEL_DIVISOR   = 10;
	// Filter accumulator fraction bits and coefficient fraction bits.
	localparam int ACC_FRAC      = 16;
	localparam int COEF_FRAC     = 24;
	// Two pi scaled by two to the COEF_FRAC, for the filter coefficient.
	localparam longint TWO_PI_Q24 = 64'd105414357;

	// Active control mode.
	typedef enum logic [1:0] {
		MODE_POSITION = 2'b00,
		MODE_VELOCITY = 2'b01,
		MODE_TORQUE   = 2'b10
	} control_mode_t;
endpackage
`default_nettype wire

// ===== testbench/aic_checker_asserts.sv
// Checker of the conditioning block's command and bus timing.
`default_nettype none
module aic_checker (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Bus handshake.
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	// Sample path.
	input wire logic sample_valid,
	input wire analog_input_conditioning_pkg::control_mode_t active_mode,
	input wire logic command_valid,
	input wire logic signed [31:0] position_cmd,
	input wire logic signed [31:0] velocity_cmd,
	input wire logic [15:0] torque_limit,
	input wire logic [31:0] velocity_limit,
	input wire logic sensor_state
);
	import analog_input_conditioning_pkg::*;
	// One clock domain, so all checks share clock and reset.
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	sequence s_taken;
		sample_valid;
	endsequence
	sequence s_answer;
		##4 command_valid;
	endsequence
	property p_lat;
		s_taken |-> s_answer;
	endproperty
	a_lat: assert property (p_lat)
		else $error("command missing four cycles after sample");
	property p_cause;
		command_valid |-> $past(sample_valid, 4);
	endproperty
	a_cause: assert property (p_cause)
		else $error("command without a sample");
	property p_pos;
		command_valid && active_mode != MODE_POSITION |-> position_cmd == 0;
	endproperty
	a_pos: assert property (p_pos)
		else $error("position command outside position mode");
	property p_vel;
		command_valid && active_mode != MODE_VELOCITY |-> velocity_cmd == 0;
	endproperty
	a_vel: assert property (p_vel)
		else $error("velocity command outside velocity mode");
	property p_tq;
		command_valid && active_mode != MODE_TORQUE |-> torque_limit == 0;
	endproperty
	a_tq: assert property (p_tq)
		else $error("torque limit outside torque mode");
	property p_vlim;
		command_valid && active_mode != MODE_TORQUE |-> velocity_limit == 0;
	endproperty
	a_vlim: assert property (p_vlim)
		else $error("velocity limit outside torque mode");
	property p_hold;
		!command_valid |-> $stable(sensor_state) && $stable(torque_limit);
	endproperty
	a_hold: assert property (p_hold)
		else $error("outputs moved without a command");
	property p_wr;
		write |-> !waitrequest;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write stalled");
	property p_rd;
		$rose(read) |-> waitrequest ##1 !waitrequest;
	endproperty
	a_rd: assert property (p_rd)
		else $error("read answer not after one wait cycle");
endmodule // aic_checker
bind analog_input_conditioning aic_checker u_chk (.clk_sys(clk_sys),
	.reset_n(reset_n), .read(read), .write(write),
	.waitrequest(waitrequest), .sample_valid(sample_valid),
	.active_mode(active_mode), .command_valid(command_valid),
	.position_cmd(position_cmd), .velocity_cmd(velocity_cmd),
	.torque_limit(torque_limit), .velocity_limit(velocity_limit),
	.sensor_state(sensor_state));
`default_nettype wire

// ===== testbench/aic_source.sv
// Behavioural analog command source that feeds converter samples.
`default_nettype none
module aic_source (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// Bench request.
	input wire logic send,
	input wire logic signed [15:0] level,
	// Converter side.
	output logic sample_valid,
	output logic signed [15:0] sample_mv
);
	timeunit 1ns;
	timeprecision 1ns;
	// Between samples the data lines toggle, so a stale value never passes.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sample_valid <= 1'b0;
			sample_mv <= 16'h0000;
		end else begin
			sample_valid <= send;
			sample_mv <= send ? level : ~sample_mv;
		end
	end
endmodule // aic_source
`default_nettype wire

// ===== testbench/analog_input_conditioning_tb_top.sv
// Self-checking bench of the analog input conditioning block.
`default_nettype none
module analog_input_conditioning_tb_top;
	import analog_input_conditioning_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {longint p, v, t, l; logic s;} exp_t;
	logic clk_sys = 1'b0, reset_n = 1'b0, read = 1'b0, write = 1'b0;
	logic send = 1'b0, sample_valid, command_valid, sensor_state;
	logic waitrequest;
	logic [5:0] address = 6'h00;
	logic [3:0] byteenable = 4'hf, be = 4'hf;
	logic [31:0] writedata = 32'h0, readdata, velocity_limit;
	logic signed [31:0] position_cmd, velocity_cmd;
	logic signed [15:0] level = 16'h0, sample_mv;
	logic [15:0] torque_limit;
	control_mode_t active_mode;
	exp_t q[$];
	int bad_count = 0, checked = 0, cycles = 0;
	int md, off, db, thr, src, sw, lastf;
	longint pg, vg, tg;
	always #20 clk_sys = ~clk_sys;
	aic_source SRC (.clk_sys(clk_sys), .reset_n(reset_n), .send(send),
		.level(level), .sample_valid(sample_valid), .sample_mv(sample_mv));
	analog_input_conditioning #(.SAMPLE_RATE_HZ(10000)) DUT (
		.clk_sys(clk_sys), .reset_n(reset_n), .address(address),
		.read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .sample_valid(sample_valid),
		.sample_mv(sample_mv), .active_mode(active_mode),
		.command_valid(command_valid), .position_cmd(position_cmd),
		.velocity_cmd(velocity_cmd), .torque_limit(torque_limit),
		.velocity_limit(velocity_limit), .sensor_state(sensor_state));
	task automatic conclude();
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checked++;
		if (got !== want) begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic chk1(input logic got, input logic want);
		checked++;
		if (got !== want) begin
			bad_count++;
			$display("wrong value at %0t: flag %b want %b", $time, got, want);
		end
	endtask
	// One Avalon transfer; the request stands until waitrequest is low.
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_sys);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		byteenable <= be;
		@(posedge clk_sys);
		while (waitrequest !== 1'b0 && n < 50) begin
			n++;
			@(posedge clk_sys);
		end
		if (n == 50) begin
			bad_count++;
			$display("wrong value at %0t: bus answer timed out", $time);
		end
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] x);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, x);
	endtask
	// Reference: offset, clamp, deadband, then scaling for the mode.
	function automatic exp_t model(input int s);
		exp_t e;
		int f;
		f = s - off;
		f = f > 10000 ? 10000 : f < -10000 ? -10000 : f;
		f = (f < 0 ? -f : f) <= db ? 0 : f;
		lastf = f;
		e.p = md == 0 ? f * pg / 10000 : 0;
		e.v = md == 1 ? f * vg / 10 : 0;
		e.s = f >= thr;
		f = f < 0 ? -f : f;
		e.t = md == 2 ? f * tg / 10000 : 0;
		e.l = md != 2 ? 0 : src != 0 ? f * vg / 10 : sw;
		return e;
	endfunction
	// Samples go out back to back; drain drops the request and waits.
	task automatic put(input int s, input logic k);
		@(posedge clk_sys);
		send <= 1'b1;
		level <= 16'(s);
		if (k)
			q.push_back(model(s));
	endtask
	task automatic drain();
		int n;
		n = 0;
		@(posedge clk_sys);
		send <= 1'b0;
		while (q.size() > 0 && n < 50) begin
			n++;
			@(posedge clk_sys);
		end
		if (q.size() > 0) begin
			bad_count++;
			$display("wrong value at %0t: commands missing", $time);
		end
	endtask
	task automatic cfg();
		logic [31:0] r;
		md = $urandom % 3;
		r = $urandom;
		if (r == 32'h80000000)
			r = 32'h7fffffff;
		pg = longint'(signed'(r));
		vg = $urandom % 101;
		tg = $urandom % 3001;
		off = int'($urandom % 20001) - 10000;
		db = $urandom % 256;
		thr = int'($urandom % 20001) - 10000;
		src = $urandom % 2;
		sw = $urandom % 100001;
		wr(REG_MODE, 32'(md));
		wr(REG_POSITION_GAIN, r);
		wr(REG_VELOCITY_GAIN, 32'(vg));
		wr(REG_TORQUE_GAIN, 32'(tg));
		wr(REG_OFFSET, 32'(off));
		wr(REG_DEADBAND, 32'(db));
		wr(REG_THRESHOLD, 32'(thr));
		wr(REG_LIMIT_SOURCE, 32'(src));
		wr(REG_SW_SPEED_LIM, 32'(sw));
	endtask
	// Each command pulse is matched with the oldest sample sent.
	always @(posedge clk_sys) begin
		exp_t e;
		if (command_valid === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			chk(position_cmd, 32'(e.p));
			chk(velocity_cmd, 32'(e.v));
			chk({16'h0, torque_limit}, 32'(e.t));
			chk(velocity_limit, 32'(e.l));
			chk1(sensor_state, e.s);
			chk(32'(active_mode), 32'(md));
		end
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			conclude();
		end
	end
	initial begin
		logic [31:0] r;
		void'($urandom(54998));
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(REG_MODE, 32'h0);
		rd(REG_POSITION_GAIN, POSITION_GAIN_RST);
		rd(REG_VELOCITY_GAIN, VELOCITY_GAIN_RST);
		rd(REG_TORQUE_GAIN, TORQUE_GAIN_RST);
		rd(REG_OFFSET, OFFSET_RST);
		rd(REG_DEADBAND, DEADBAND_RST);
		rd(REG_FILTER, FILTER_RST);
		rd(REG_THRESHOLD, THRESHOLD_RST);
		rd(REG_LIMIT_SOURCE, 32'(LIMIT_SOURCE_RST));
		rd(REG_SW_SPEED_LIM, SW_SPEED_LIM_RST);
		rd(6'h30, 32'h0);
		wr(REG_MODE, 32'h3);
		rd(REG_MODE, 32'h0);
		wr(REG_TORQUE_GAIN, 32'hffff);
		rd(REG_TORQUE_GAIN, TORQUE_GAIN_MAX);
		be = 4'h1;
		wr(REG_VELOCITY_GAIN, 32'hffffff07);
		be = 4'hf;
		rd(REG_VELOCITY_GAIN, 32'h7);
		$display("test registers done");
		put(10000, 1'b0);
		drain();
		repeat (6) @(posedge clk_sys);
		bus(1'b0, REG_FILTERED, 32'h0, r);
		chk1(signed'(r) > 0 && signed'(r) < 10000, 1'b1);
		wr(REG_FILTER, 32'h0);
		$display("test filter done");
		for (int i = 0; i < 30; i++) begin
			cfg();
			put(off + db, 1'b1);
			put(off - db, 1'b1);
			put(off + db + 1, 1'b1);
			put(off + thr, 1'b1);
			put(32767, 1'b1);
			put(-32768, 1'b1);
			put(int'($urandom % 20001) - 10000, 1'b1);
			drain();
			rd(REG_FILTERED, 32'(lastf));
		end
		$display("test random done");
		conclude();
	end
endmodule // analog_input_conditioning_tb_top
`default_nettype wire
